// file: bench/analog_io_param_decode_bench.sv
module analog_io_param_decode_bench;
	timeunit 1ns;
	timeprecision 1ns;
	// shortened periods per rate code, to keep the run small
	localparam int AT[4] = '{20, 40, 60, 80};
	localparam int RT[4] = '{24, 32, 48, 64};
	logic sys_clk = 1'b0;
	logic resetn, param_wr;
	logic [1:0] param_sel, four_in_rate, mixed_in_current_sel, mixed_out_current_sel;
	logic [1:0] mixed_rate, rtd_unit, rtd_rate;
	logic [7:0] param_wdata, four_input_analog_config, mixed_analog_io_config;
	logic [7:0] thermo_sensor_type_select, thermo_unit_and_rate, rtd_sensor_types;
	logic [3:0] four_in_current_sel;
	logic four_in_pending, mixed_pending, rtd_pending, four_in_avg_en, mixed_avg_en;
	logic four_in_meas_tick, mixed_meas_tick, rtd_meas_tick;
	logic [7:0] st[4], ap[4], d_s;
	logic [2:0] pend, ptk, tk;
	logic [1:0] s_s;
	logic w_s, r_s;
	int gap[3];
	int bad_count = 0;
	int n_checks = 0;

	analog_io_param_decode #(.AIO_20_CYC(AT[0]), .AIO_100_CYC(AT[1]), .AIO_200_CYC(AT[2]),
		.AIO_500_CYC(AT[3]), .RTD_250_CYC(RT[0]), .RTD_1000_CYC(RT[1]),
		.RTD_2500_CYC(RT[2]), .RTD_10000_CYC(RT[3])) analog_io_param_decode_inst (
		.sys_clk(sys_clk),
		.resetn(resetn),
		.param_wr(param_wr),
		.param_sel(param_sel),
		.param_wdata(param_wdata),
		.four_input_analog_config(four_input_analog_config),
		.mixed_analog_io_config(mixed_analog_io_config),
		.thermo_sensor_type_select(thermo_sensor_type_select),
		.thermo_unit_and_rate(thermo_unit_and_rate),
		.four_in_pending(four_in_pending),
		.mixed_pending(mixed_pending),
		.rtd_pending(rtd_pending),
		.four_in_current_sel(four_in_current_sel),
		.four_in_rate(four_in_rate),
		.four_in_avg_en(four_in_avg_en),
		.four_in_meas_tick(four_in_meas_tick),
		.mixed_in_current_sel(mixed_in_current_sel),
		.mixed_out_current_sel(mixed_out_current_sel),
		.mixed_rate(mixed_rate),
		.mixed_avg_en(mixed_avg_en),
		.mixed_meas_tick(mixed_meas_tick),
		.rtd_sensor_types(rtd_sensor_types),
		.rtd_unit(rtd_unit),
		.rtd_rate(rtd_rate),
		.rtd_meas_tick(rtd_meas_tick)
	);
	fieldbus_cfg_model fieldbus_cfg_model_inst (
		.sys_clk(sys_clk),
		.param_wr(param_wr),
		.param_sel(param_sel),
		.param_wdata(param_wdata)
	);

	// 50 ns period
	always #25 sys_clk = ~sys_clk;
	assign tk = {rtd_meas_tick, mixed_meas_tick, four_in_meas_tick};

	function automatic logic [1:0] rix(int m);
		return (m < 2) ? ap[m][5:4] : ap[3][3:2];
	endfunction
	function automatic int per(int m);
		return (m < 2) ? AT[rix(m)] : RT[rix(m)];
	endfunction
	function automatic logic [7:0] msk(logic [1:0] s);
		return (s < 2) ? 8'h7F : (s == 2'h3) ? 8'h0F : 8'hFF;
	endfunction
	task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("unexpected %s expected %0h seen %0h", nm, exp, seen);
		end
	endtask
	task close_out();
		$display("checks %0d mismatches %0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	// capture inputs at the edge the design sees them, to avoid a race at negedge
	always @(posedge sys_clk) begin
		w_s <= param_wr;
		s_s <= param_sel;
		d_s <= param_wdata;
		r_s <= resetn;
	end

	// reference model, stepped once a cycle, then compared with the design
	always @(negedge sys_clk) begin
		if (!r_s) begin
			st = '{8'h10, 8'h10, 8'h00, 8'h00};
			ap = st;
			pend = '0;
			gap = '{0, 0, 0};
		end else begin
			// a tick seen at this edge copies what was stored before it
			for (int m = 0; m < 3; m++) begin
				if (ptk[m]) begin
					ap[m] = st[m];
					if (m == 2)
						ap[3] = st[3];
					pend[m] = 1'b0;
				end
			end
			// a write on a tick edge waits for the following tick
			if (w_s) begin
				st[s_s] = d_s & msk(s_s);
				pend[(s_s == 2'h3) ? 2 : s_s] = 1'b1;
			end
			// every cycle: a tick is due exactly one applied period after the last,
			// so a tick that never comes is caught as well
			for (int m = 0; m < 3; m++) begin
				gap[m]++;
				chk("tick", tk[m], gap[m] == per(m));
				if (tk[m])
					gap[m] = 0;
			end
		end
		ptk = tk;
		chk("stored_four", four_input_analog_config, st[0]);
		chk("stored_mixed", mixed_analog_io_config, st[1]);
		chk("stored_type", thermo_sensor_type_select, st[2]);
		chk("stored_unit", thermo_unit_and_rate, st[3]);
		chk("pending", {rtd_pending, mixed_pending, four_in_pending}, pend);
		chk("four_sel", four_in_current_sel, ap[0][3:0]);
		chk("four_upper", {four_in_avg_en, four_in_rate}, ap[0][6:4]);
		chk("mixed_sel", {mixed_out_current_sel, mixed_in_current_sel}, ap[1][3:0]);
		chk("mixed_upper", {mixed_avg_en, mixed_rate}, ap[1][6:4]);
		chk("rtd_types", rtd_sensor_types, ap[2]);
		chk("rtd_unit", {rtd_rate, rtd_unit}, ap[3][3:0]);
	end

	// main sequence
	initial begin
		resetn = 1'b0;
		void'($urandom(97));
		repeat (12) @(negedge sys_clk);
		resetn = 1'b1;
		repeat (100) @(negedge sys_clk);
		fieldbus_cfg_model_inst.set_rate(st[0], 2'h2);
		repeat (250) @(negedge sys_clk);
		// every rate, averaging, type and unit code, back to back, reserved bits set
		for (int r = 0; r < 4; r++) begin
			fieldbus_cfg_model_inst.put(2'h0, 8'(8'h80 | r << 4 | 1 << r | (r & 1) << 6));
			fieldbus_cfg_model_inst.put(2'h1, 8'(8'h80 | r << 4 | 4'hF >> r | (r >> 1) << 6));
			fieldbus_cfg_model_inst.put(2'h2, 8'(r * 8'h55));
			fieldbus_cfg_model_inst.put(2'h3, 8'(8'hF0 | r * 5));
			fieldbus_cfg_model_inst.idle();
			repeat (250) @(negedge sys_clk);
		end
		repeat (30) begin
			fieldbus_cfg_model_inst.put(2'($urandom_range(3, 0)), 8'($urandom));
			if ($urandom_range(1, 0))
				fieldbus_cfg_model_inst.idle();
			repeat ($urandom_range(40, 0)) @(negedge sys_clk);
		end
		fieldbus_cfg_model_inst.idle();
		// reset in mid-run must bring every default back
		resetn = 1'b0;
		repeat (3) @(negedge sys_clk);
		resetn = 1'b1;
		repeat (150) @(negedge sys_clk);
		close_out();
	end

	// about 2.2k cycles expected, 2.8k at most; 1 ms leaves a wide margin
	initial begin
		#1000000;
		bad_count++;
		close_out();
	end
endmodule

// file: bench/fieldbus_cfg_model.sv
module fieldbus_cfg_model (
	// clock
	input wire logic sys_clk,
	// parameter write port
	output logic param_wr,
	output logic [1:0] param_sel,
	output logic [7:0] param_wdata
);
	timeunit 1ns;
	timeprecision 1ns;
	// quiet port from time zero
	initial begin
		param_wr = 1'b0;
		param_sel = 2'h0;
		param_wdata = 8'h00;
	end
	// strobe stays up until idle, so calls in a row go back to back
	task put(input logic [1:0] s, input logic [7:0] d);
		@(negedge sys_clk);
		param_wr = 1'b1;
		param_sel = s;
		param_wdata = d;
	endtask
	// released lines flip so a stale byte cannot pass for a fresh one
	task idle();
		@(negedge sys_clk);
		param_wr = 1'b0;
		param_sel = ~param_sel;
		param_wdata = ~param_wdata;
	endtask
	// rewrite only the refresh field, rest kept as read back
	task set_rate(input logic [7:0] cur, input logic [1:0] r);
		put(2'h0, {cur[7:6], r, cur[3:0]});
		idle();
	endtask
endmodule

// file: bench/param_decode_sva.sv
module param_decode_sva
	import param_decode_pkg::*;
(
	// clock and reset
	input wire logic sys_clk,
	input wire logic resetn,
	// write port
	input wire logic param_wr,
	input wire logic [1:0] param_sel,
	input wire logic [7:0] param_wdata,
	// stored bytes
	input wire logic [7:0] four_input_analog_config,
	input wire logic [7:0] mixed_analog_io_config,
	input wire logic [7:0] thermo_unit_and_rate,
	// applied settings and status
	input wire logic four_in_pending,
	input wire logic rtd_pending,
	input wire logic [3:0] four_in_current_sel,
	input wire logic [1:0] four_in_rate,
	input wire logic four_in_avg_en,
	input wire logic four_in_meas_tick,
	input wire logic [1:0] rtd_unit,
	input wire logic [1:0] rtd_rate,
	input wire logic rtd_meas_tick
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!resetn);

	// one byte strobed in for the given selector
	sequence s_wr(logic [1:0] s);
		param_wr && param_sel == s;
	endsequence
	// a tick with no write beside it, so nothing may stay pending
	sequence s_quiet_rtd_tick;
		rtd_meas_tick && !param_wr;
	endsequence
	// shortest period is far above eight cycles
	sequence s_no_tick8;
		!four_in_meas_tick [*8];
	endsequence

	a_four_byte_stored: assert property (
		s_wr(SEL_FOUR_IN) |=> four_input_analog_config == ($past(param_wdata) & 8'h7F))
		else $error("four-input byte not stored as written");
	a_mixed_byte_stored: assert property (
		s_wr(SEL_MIXED) |=> mixed_analog_io_config == ($past(param_wdata) & 8'h7F))
		else $error("mixed byte not stored as written");
	a_unit_byte_stored: assert property (
		s_wr(SEL_RTD_UNIT) |=> thermo_unit_and_rate == ($past(param_wdata) & 8'h0F))
		else $error("unit byte not stored as written");
	a_pend_raised: assert property (
		s_wr(SEL_FOUR_IN) |=> four_in_pending)
		else $error("pending not raised by write");
	a_four_applied: assert property (
		four_in_meas_tick |=> {1'b0, four_in_avg_en, four_in_rate, four_in_current_sel}
			== $past(four_input_analog_config))
		else $error("four-input settings not applied at tick");
	a_rtd_held: assert property (
		!rtd_meas_tick |=> $stable({rtd_unit, rtd_rate}))
		else $error("thermometer settings changed without tick");
	a_rtd_pend_clear: assert property (
		s_quiet_rtd_tick |=> !rtd_pending)
		else $error("thermometer pending not cleared at tick");
	a_tick_one_cycle: assert property (
		four_in_meas_tick |=> s_no_tick8)
		else $error("measurement tick too long or too close");
endmodule

bind analog_io_param_decode param_decode_sva param_decode_sva_inst (
	.sys_clk(sys_clk),
	.resetn(resetn),
	.param_wr(param_wr),
	.param_sel(param_sel),
	.param_wdata(param_wdata),
	.four_input_analog_config(four_input_analog_config),
	.mixed_analog_io_config(mixed_analog_io_config),
	.thermo_unit_and_rate(thermo_unit_and_rate),
	.four_in_pending(four_in_pending),
	.rtd_pending(rtd_pending),
	.four_in_current_sel(four_in_current_sel),
	.four_in_rate(four_in_rate),
	.four_in_avg_en(four_in_avg_en),
	.four_in_meas_tick(four_in_meas_tick),
	.rtd_unit(rtd_unit),
	.rtd_rate(rtd_rate),
	.rtd_meas_tick(rtd_meas_tick)
);

// file: hdl/analog_io_param_decode.sv
// Notes on behaviour
// [RULE1] four-input bits 0-3: voltage zero, current one
// [RULE2] four-input bits 5:4 pick 20/100/200/500 ms refresh
// [RULE3] four-input bit 6 averaging; bit 7 reserved zero
// [RULE4] mixed module: inputs, outputs, then same upper layout
// [RULE5] thermometer byte one: four two-bit sensor types
// [RULE6] thermometer byte two: unit, refresh rate, reserved
// [RULE7] configurator changes only the refresh field
// [RULE8] whole byte latched, applied at next cycle
module analog_io_param_decode
	import param_decode_pkg::*;
#(
	parameter int unsigned AIO_20_CYC = param_decode_pkg::CYC_AIO_20,
	parameter int unsigned AIO_100_CYC = param_decode_pkg::CYC_AIO_100,
	parameter int unsigned AIO_200_CYC = param_decode_pkg::CYC_AIO_200,
	parameter int unsigned AIO_500_CYC = param_decode_pkg::CYC_AIO_500,
	parameter int unsigned RTD_250_CYC = param_decode_pkg::CYC_RTD_250,
	parameter int unsigned RTD_1000_CYC = param_decode_pkg::CYC_RTD_1000,
	parameter int unsigned RTD_2500_CYC = param_decode_pkg::CYC_RTD_2500,
	parameter int unsigned RTD_10000_CYC = param_decode_pkg::CYC_RTD_10000
) (
	// clock and reset
	input wire logic sys_clk,
	input wire logic resetn,
	// parameter element write port
	input wire logic param_wr,
	input wire logic [1:0] param_sel,
	input wire logic [7:0] param_wdata,
	// parameter bytes as last written (read back)
	output logic [7:0] four_input_analog_config,
	output logic [7:0] mixed_analog_io_config,
	output logic [7:0] thermo_sensor_type_select,
	output logic [7:0] thermo_unit_and_rate,
	// written but not yet applied
	output logic four_in_pending,
	output logic mixed_pending,
	output logic rtd_pending,
	// four-input module, applied settings
	output logic [3:0] four_in_current_sel,
	output logic [1:0] four_in_rate,
	output logic four_in_avg_en,
	output logic four_in_meas_tick,
	// mixed module, applied settings
	output logic [1:0] mixed_in_current_sel,
	output logic [1:0] mixed_out_current_sel,
	output logic [1:0] mixed_rate,
	output logic mixed_avg_en,
	output logic mixed_meas_tick,
	// thermometer module, applied settings
	output logic [7:0] rtd_sensor_types,
	output logic [1:0] rtd_unit,
	output logic [1:0] rtd_rate,
	output logic rtd_meas_tick
);

	logic [7:0] four_in_active_reg;
	logic [7:0] mixed_active_reg;
	logic [7:0] rtd_type_active_reg;
	logic [7:0] rtd_unit_active_reg;
	logic [CNT_W-1:0] four_in_period;
	logic [CNT_W-1:0] mixed_period;
	logic [CNT_W-1:0] rtd_period;
	logic four_in_wr;
	logic mixed_wr;
	logic type_wr;
	logic unit_wr;

	assign four_in_wr = param_wr && (param_sel == SEL_FOUR_IN);
	assign mixed_wr = param_wr && (param_sel == SEL_MIXED);
	assign type_wr = param_wr && (param_sel == SEL_RTD_TYPE);
	assign unit_wr = param_wr && (param_sel == SEL_RTD_UNIT);

	// written bytes are stored whole; reserved bits are forced to zero so a
	// stray one there can never reach the decode
	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			four_input_analog_config <= FOUR_IN_RESET;
			mixed_analog_io_config <= MIXED_RESET;
			thermo_sensor_type_select <= RTD_TYPE_RESET;
			thermo_unit_and_rate <= RTD_UNIT_RESET;
		end else begin
			if (four_in_wr) begin
				four_input_analog_config <= param_wdata & AIO_WRITE_MASK; // [RULE3] [RULE8]
			end
			if (mixed_wr) begin
				mixed_analog_io_config <= param_wdata & AIO_WRITE_MASK; // [RULE4] [RULE8]
			end
			if (type_wr) begin
				thermo_sensor_type_select <= param_wdata; // [RULE5] [RULE8]
			end
			if (unit_wr) begin
				thermo_unit_and_rate <= param_wdata & RTD_UNIT_WRITE_MASK; // [RULE6] [RULE8]
			end
		end
	end

	// pending flags: a write in the same cycle as the applying tick wins,
	// since that write has not been copied yet
	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			four_in_pending <= 1'b0;
		end else if (four_in_wr) begin
			four_in_pending <= 1'b1; // [RULE8]
		end else if (four_in_meas_tick) begin
			four_in_pending <= 1'b0; // [RULE8]
		end
	end

	// mixed module pending flag, same set-wins order
	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			mixed_pending <= 1'b0;
		end else if (mixed_wr) begin
			mixed_pending <= 1'b1; // [RULE8]
		end else if (mixed_meas_tick) begin
			mixed_pending <= 1'b0; // [RULE8]
		end
	end

	// both thermometer bytes share one flag because they are applied together
	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			rtd_pending <= 1'b0;
		end else if (type_wr || unit_wr) begin
			rtd_pending <= 1'b1; // [RULE8]
		end else if (rtd_meas_tick) begin
			rtd_pending <= 1'b0; // [RULE8]
		end
	end

	// settings take effect only at a cycle boundary, so one measurement never
	// mixes old and new sensor kinds; cost is up to one period of latency
	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			four_in_active_reg <= FOUR_IN_RESET;
		end else if (four_in_meas_tick) begin
			four_in_active_reg <= four_input_analog_config; // [RULE8]
		end
	end

	// mixed module applied byte
	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			mixed_active_reg <= MIXED_RESET;
		end else if (mixed_meas_tick) begin
			mixed_active_reg <= mixed_analog_io_config; // [RULE8]
		end
	end

	// thermometer bytes move together so type and unit never disagree
	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			rtd_type_active_reg <= RTD_TYPE_RESET;
			rtd_unit_active_reg <= RTD_UNIT_RESET;
		end else if (rtd_meas_tick) begin
			rtd_type_active_reg <= thermo_sensor_type_select; // [RULE8]
			rtd_unit_active_reg <= thermo_unit_and_rate; // [RULE8]
		end
	end

	// field decode of the applied bytes, straight slices of flip-flops
	assign four_in_current_sel = four_in_active_reg[AIO_SEL_LSB +: AIO_SEL_W]; // [RULE1]
	assign four_in_rate = four_in_active_reg[AIO_RATE_LSB +: 2]; // [RULE2]
	assign four_in_avg_en = four_in_active_reg[AIO_AVG_BIT]; // [RULE3]
	assign mixed_in_current_sel = mixed_active_reg[AIO_SEL_LSB +: 2]; // [RULE4]
	assign mixed_out_current_sel = mixed_active_reg[AIO_SEL_LSB + 2 +: 2]; // [RULE4]
	assign mixed_rate = mixed_active_reg[AIO_RATE_LSB +: 2]; // [RULE4]
	assign mixed_avg_en = mixed_active_reg[AIO_AVG_BIT]; // [RULE4]
	assign rtd_sensor_types = rtd_type_active_reg; // [RULE5]
	assign rtd_unit = rtd_unit_active_reg[RTD_UNIT_LSB +: 2]; // [RULE6]
	assign rtd_rate = rtd_unit_active_reg[RTD_RATE_LSB +: 2]; // [RULE6]

	// refresh period lookup for the four-input module
	always_comb begin
		case (aio_rate_t'(four_in_rate))
			AIO_RATE_20MS: four_in_period = CNT_W'(AIO_20_CYC); // [RULE2]
			AIO_RATE_100MS: four_in_period = CNT_W'(AIO_100_CYC); // [RULE2]
			AIO_RATE_200MS: four_in_period = CNT_W'(AIO_200_CYC); // [RULE2]
			AIO_RATE_500MS: four_in_period = CNT_W'(AIO_500_CYC); // [RULE2]
			default: four_in_period = CNT_W'(AIO_100_CYC);
		endcase
	end

	// refresh period lookup for the mixed module
	always_comb begin
		case (aio_rate_t'(mixed_rate))
			AIO_RATE_20MS: mixed_period = CNT_W'(AIO_20_CYC); // [RULE4]
			AIO_RATE_100MS: mixed_period = CNT_W'(AIO_100_CYC); // [RULE4]
			AIO_RATE_200MS: mixed_period = CNT_W'(AIO_200_CYC); // [RULE4]
			AIO_RATE_500MS: mixed_period = CNT_W'(AIO_500_CYC); // [RULE4]
			default: mixed_period = CNT_W'(AIO_100_CYC);
		endcase
	end

	// refresh period lookup for the thermometer module
	always_comb begin
		case (rtd_rate_t'(rtd_rate))
			RTD_RATE_250MS: rtd_period = CNT_W'(RTD_250_CYC); // [RULE6]
			RTD_RATE_1S: rtd_period = CNT_W'(RTD_1000_CYC); // [RULE6]
			RTD_RATE_2500MS: rtd_period = CNT_W'(RTD_2500_CYC); // [RULE6]
			RTD_RATE_10S: rtd_period = CNT_W'(RTD_10000_CYC); // [RULE6]
			default: rtd_period = CNT_W'(RTD_250_CYC);
		endcase
	end

	// one measurement-cycle timer per module
	meas_cycle_timer #(.W(CNT_W)) four_in_timer (
		.sys_clk(sys_clk),
		.resetn(resetn),
		.period(four_in_period),
		.tick(four_in_meas_tick)
	);

	meas_cycle_timer #(.W(CNT_W)) mixed_timer (
		.sys_clk(sys_clk),
		.resetn(resetn),
		.period(mixed_period),
		.tick(mixed_meas_tick)
	);

	meas_cycle_timer #(.W(CNT_W)) rtd_timer (
		.sys_clk(sys_clk),
		.resetn(resetn),
		.period(rtd_period),
		.tick(rtd_meas_tick)
	);

endmodule

// file: hdl/meas_cycle_timer.sv
module meas_cycle_timer
	import param_decode_pkg::*;
#(
	parameter int unsigned W = param_decode_pkg::CNT_W
) (
	// clock and reset
	input wire logic sys_clk,
	input wire logic resetn,
	// period in clock cycles, at least one
	input wire logic [W-1:0] period,
	// one-cycle pulse at the start of each measurement cycle
	output logic tick
);

	logic [W-1:0] count_reg;

	// counting up and comparing with the last value tolerates a period that
	// shrinks below the current count: the cycle simply ends at once
	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			count_reg <= '0;
			tick <= 1'b0;
		end else if (count_reg >= period - W'(1)) begin
			count_reg <= '0;
			tick <= 1'b1;
		end else begin
			count_reg <= count_reg + W'(1);
			tick <= 1'b0;
		end
	end

endmodule

// file: hdl/param_decode_pkg.sv
package param_decode_pkg;

	// system clock rate
	localparam int unsigned CLK_HZ = 20_000_000;
	localparam int unsigned MS_PER_S = 1000;

	// refresh periods of the voltage/current modules, in milliseconds
	localparam int unsigned T_AIO_20_MS = 20;
	localparam int unsigned T_AIO_100_MS = 100;
	localparam int unsigned T_AIO_200_MS = 200;
	localparam int unsigned T_AIO_500_MS = 500;

	// refresh periods of the thermometer module, in milliseconds
	localparam int unsigned T_RTD_250_MS = 250;
	localparam int unsigned T_RTD_1000_MS = 1000;
	localparam int unsigned T_RTD_2500_MS = 2500;
	localparam int unsigned T_RTD_10000_MS = 10000;

	// cycle counts derived from the times; 10 s at 20 MHz fits in 28 bits
	localparam int unsigned CYC_AIO_20 = T_AIO_20_MS * (CLK_HZ / MS_PER_S);
	localparam int unsigned CYC_AIO_100 = T_AIO_100_MS * (CLK_HZ / MS_PER_S);
	localparam int unsigned CYC_AIO_200 = T_AIO_200_MS * (CLK_HZ / MS_PER_S);
	localparam int unsigned CYC_AIO_500 = T_AIO_500_MS * (CLK_HZ / MS_PER_S);
	localparam int unsigned CYC_RTD_250 = T_RTD_250_MS * (CLK_HZ / MS_PER_S);
	localparam int unsigned CYC_RTD_1000 = T_RTD_1000_MS * (CLK_HZ / MS_PER_S);
	localparam int unsigned CYC_RTD_2500 = T_RTD_2500_MS * (CLK_HZ / MS_PER_S);
	localparam int unsigned CYC_RTD_10000 = T_RTD_10000_MS * (CLK_HZ / MS_PER_S);
	localparam int unsigned CNT_W = 28;

	// parameter byte selector on the write port
	localparam logic [1:0] SEL_FOUR_IN = 2'h0;
	localparam logic [1:0] SEL_MIXED = 2'h1;
	localparam logic [1:0] SEL_RTD_TYPE = 2'h2;
	localparam logic [1:0] SEL_RTD_UNIT = 2'h3;

	// field positions of the voltage/current parameter bytes
	localparam int unsigned AIO_SEL_LSB = 0;
	localparam int unsigned AIO_SEL_W = 4;
	localparam int unsigned AIO_RATE_LSB = 4;
	localparam int unsigned AIO_AVG_BIT = 6;
	// bit 7 reserved
	localparam logic [7:0] AIO_WRITE_MASK = 8'h7F;

	// field positions of the thermometer second byte; bits 7:4 reserved
	localparam int unsigned RTD_UNIT_LSB = 0;
	localparam int unsigned RTD_RATE_LSB = 2;
	localparam logic [7:0] RTD_UNIT_WRITE_MASK = 8'h0F;

	// values after reset: 100 ms refresh on the voltage/current modules, 250 ms on the thermometer, voltage everywhere, averaging off
	localparam logic [7:0] FOUR_IN_RESET = 8'h10;
	localparam logic [7:0] MIXED_RESET = 8'h10;
	localparam logic [7:0] RTD_TYPE_RESET = 8'h00;
	localparam logic [7:0] RTD_UNIT_RESET = 8'h00;

	// refresh rate codes
	typedef enum logic [1:0] {
		AIO_RATE_20MS,
		AIO_RATE_100MS,
		AIO_RATE_200MS,
		AIO_RATE_500MS
	} aio_rate_t;

	typedef enum logic [1:0] {
		RTD_RATE_250MS,
		RTD_RATE_1S,
		RTD_RATE_2500MS,
		RTD_RATE_10S
	} rtd_rate_t;

	// thermometer sensor kinds and display units
	typedef enum logic [1:0] {
		RTD_UNUSED,
		RTD_PT100,
		RTD_PT1000,
		RTD_NI1000
	} rtd_sensor_t;

	typedef enum logic [1:0] {
		UNIT_CELSIUS,
		UNIT_FAHRENHEIT,
		UNIT_BINARY,
		UNIT_UNDEFINED
	} rtd_unit_t;

endpackage
